// >>> rtl/sap_top.sv
// Serial audio ports: burst output, I2S master and slave, register slave.
`timescale 1ns/10ps
module sap_top (
   input wire logic clock,
   input wire logic nrst,
   input wire sap_pkg::sap_axi_req_s axi_req,
   output sap_pkg::sap_axi_rsp_s axi_rsp,
   input wire logic usb_stream_clk,
   input wire logic usb_stream_bit,
   input wire logic usb_stream_valid,
   input wire logic [3:0] usb_stream_ep,
   input wire logic [47:0] usb_play_word,
   input wire logic usb_play_valid,
   output sap_pkg::sap_sample_s apu_play,
   output logic apu_play_valid,
   input wire sap_pkg::sap_sample_s apu_rec,
   input wire logic apu_rec_valid,
   output logic [31:0] usb_rec_word,
   output logic usb_rec_valid,
   input wire sap_pkg::sap_sample_s apu_tx,
   output logic apu_tx_ready,
   output sap_pkg::sap_sample_s apu_rx,
   output logic apu_rx_valid,
   output logic [1:0] mclk_sel,
   output logic uc_load_req,
   input wire logic bit_clock_in,
   output logic bit_clock_out,
   output logic bit_clock_oe,
   input wire logic word_strobe_in,
   output logic word_strobe_out,
   output logic word_strobe_oe,
   input wire logic serial_audio_data_in,
   output logic serial_audio_data_out,
   output logic burst_clock_pin,
   output logic burst_data_pin,
   output logic burst_word_strobe_out
);
   import sap_pkg::*;

   typedef struct packed {
      sap_ctrl_s ctrl;
      logic aw_have;
      logic [7:0] awaddr;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] hold_byte;
      logic hold_full;
      logic [7:0] sh_byte;
      logic [3:0] sh_cnt;
      logic sclk;
      logic [15:0] sacc;
      logic ovf;
      logic [15:0] macc;
      logic mbclk;
      logic [5:0] midx;
      logic mws;
      logic [31:0] mtx;
      logic [31:0] txr;
      logic mdout;
      logic tx_ready;
      logic [31:0] mrx;
      logic [31:0] left_tmp;
      logic [1:0] rise_d;
      logic din_s1;
      logic din_s2;
      logic tog_s1;
      logic tog_s2;
      logic tog_s3;
      sap_sample_s rx;
      logic rx_valid;
      logic rx_seen;
      sap_sample_s play;
      logic play_valid;
      logic [31:0] rec_word;
      logic rec_valid;
   } sap_main_s;

   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic [2:0] cfg_s1;
      logic [2:0] cfg_s2;
      logic ws_prev;
      logic [31:0] sr;
      logic [5:0] cnt;
      logic [31:0] left;
      sap_sample_s hold;
      logic tog;
   } sap_link_s;

   sap_main_s main_r;
   sap_main_s main_nxt;
   sap_link_s link_r;
   sap_link_s link_nxt;

   function automatic logic [31:0] sap_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Left-aligns a slot word; a 16-bit slot keeps only its lower half, moved to the top.
   function automatic logic [31:0] sap_align(input logic [31:0] w, input logic slot32);
      return slot32 ? w : {w[15:0], 16'h0000};
   endfunction

   function automatic sap_sample_s sap_play_unpack(input logic [47:0] w,
                                                   input logic [1:0] fmt);
      sap_sample_s s;
      case (fmt)
         PLAY_MONO16: begin
            s.left = {w[15:0], 16'h0000};
            s.right = {w[15:0], 16'h0000};
         end
         PLAY_STEREO16: begin
            s.left = {w[15:0], 16'h0000};
            s.right = {w[31:16], 16'h0000};
         end
         PLAY_STEREO24: begin
            s.left = {w[23:0], 8'h00};
            s.right = {w[47:24], 8'h00};
         end
         default: begin
            s = '0;
         end
      endcase
      return s;
   endfunction

   function automatic logic [31:0] sap_rec_pack(input sap_sample_s s, input logic [1:0] fmt);
      case (fmt)
         REC_MONO8: return {24'h000000, s.left[31:24]};
         REC_MONO16: return {16'h0000, s.left[31:16]};
         REC_STEREO16: return {s.right[31:16], s.left[31:16]};
         default: return 32'h00000000;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Main clock domain
   // ----------------------------------------------------------------
   always_comb begin
      sap_ctrl_s newc;
      logic [31:0] wv;
      logic [7:0] waddr;
      logic [7:0] raddr;
      logic [16:0] ssum;
      logic [16:0] msum;
      logic burst_ctl;
      logic master_on;
      logic slot32;
      logic [5:0] last;
      logic [5:0] slot;
      logic [5:0] nidx;
      logic [5:0] wsidx;
      logic left_lvl;
      logic [31:0] rxw;
      newc = main_r.ctrl;
      wv = 32'h00000000;
      waddr = main_r.awaddr & 8'hfc;
      raddr = axi_req.araddr & 8'hfc;
      main_nxt = main_r;
      main_nxt.rise_d = {main_r.rise_d[0], 1'b0};
      main_nxt.tx_ready = 1'b0;
      main_nxt.rx_valid = 1'b0;
      main_nxt.din_s1 = serial_audio_data_in;
      main_nxt.din_s2 = main_r.din_s1;
      main_nxt.tog_s1 = link_r.tog;
      main_nxt.tog_s2 = main_r.tog_s1;
      main_nxt.tog_s3 = main_r.tog_s2;
      burst_ctl = main_r.ctrl.burst_en && !main_r.ctrl.direct;
      master_on = main_r.ctrl.mode == SAP_SYNC || main_r.ctrl.mode == SAP_ASYNC_IO;
      slot32 = main_r.ctrl.mode == SAP_ASYNC_IO ? main_r.ctrl.slot32_b : main_r.ctrl.slot32_a;
      last = slot32 ? 6'd63 : 6'd31;
      slot = slot32 ? 6'd32 : 6'd16;
      left_lvl = main_r.ctrl.ws_left_high;

      // ----------------------------------------------------------------
      // Controller streaming shifter
      // ----------------------------------------------------------------
      // shift clock rate
      ssum = {1'b0, main_r.sacc} +
         {1'b0, 16'(SHIFT_STEP_MAX / (16'(main_r.ctrl.div_sel) + 16'd1))};
      if (!burst_ctl) begin
         main_nxt.sh_cnt = 4'h0;
         main_nxt.sclk = 1'b0;
         main_nxt.sacc = 16'h0000;
      end else begin
         main_nxt.sacc = ssum[15:0];
         if (main_r.sh_cnt == 4'h0) begin
            if (main_r.hold_full) begin
               main_nxt.sh_byte = main_r.hold_byte;
               main_nxt.sh_cnt = 4'd8;
               main_nxt.hold_full = 1'b0;
            end
         end else if (ssum[16]) begin
            main_nxt.sclk = !main_r.sclk;
            if (main_r.sclk) begin
               if (main_r.sh_cnt != 4'h1) begin
                  main_nxt.sh_byte = {main_r.sh_byte[6:0], 1'b0};
                  main_nxt.sh_cnt = main_r.sh_cnt - 4'h1;
               end else if (main_r.hold_full) begin
                  main_nxt.sh_byte = main_r.hold_byte;
                  main_nxt.sh_cnt = 4'd8;
                  main_nxt.hold_full = 1'b0;
               end else begin
                  main_nxt.sh_cnt = 4'h0;
               end
            end
         end
      end

      // ----------------------------------------------------------------
      // Register slave
      // ----------------------------------------------------------------
      if (axi_req.awvalid && axi_rsp.awready) begin
         main_nxt.aw_have = 1'b1;
         main_nxt.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
         main_nxt.w_have = 1'b1;
         main_nxt.wdata = axi_req.wdata;
         main_nxt.wstrb = axi_req.wstrb;
      end
      if (main_r.bvalid && axi_req.bready) begin
         main_nxt.bvalid = 1'b0;
      end
      if (main_r.aw_have && main_r.w_have && !main_r.bvalid) begin
         main_nxt.aw_have = 1'b0;
         main_nxt.w_have = 1'b0;
         main_nxt.bvalid = 1'b1;
         main_nxt.bresp = RESP_OKAY;
         case (waddr)
            REG_CTRL: begin
               wv = sap_merge({{(32 - CTRL_W){1'b0}}, main_r.ctrl}, main_r.wdata,
                              main_r.wstrb);
               newc = sap_ctrl_s'(wv[CTRL_W-1:0]);
               if ((newc.burst_en && newc.mode == SAP_ASYNC_IO) || newc.mclk_sel == FMT_BAD ||
                   newc.play_fmt == FMT_BAD || newc.rec_fmt == FMT_BAD) begin
                  main_nxt.bresp = RESP_SLVERR;
               end else begin
                  main_nxt.ctrl = newc;
               end
            end
            REG_TXBYTE: begin
               if (main_r.wstrb[0]) begin
                  if (main_nxt.hold_full) begin
                     main_nxt.ovf = 1'b1;
                  end else begin
                     main_nxt.hold_byte = main_r.wdata[7:0];
                     main_nxt.hold_full = 1'b1;
                  end
               end
            end
            REG_STATUS: begin
               if (main_r.wstrb[0] && main_r.wdata[ST_OVERFLOW]) begin
                  main_nxt.ovf = 1'b0;
               end
               if (main_r.wstrb[0] && main_r.wdata[ST_RX_SEEN]) begin
                  main_nxt.rx_seen = 1'b0;
               end
            end
            REG_RXL, REG_RXR: begin
            end
            default: begin
               main_nxt.bresp = RESP_DECERR;
            end
         endcase
      end
      if (main_r.rvalid && axi_req.rready) begin
         main_nxt.rvalid = 1'b0;
      end
      if (axi_req.arvalid && axi_rsp.arready) begin
         main_nxt.rvalid = 1'b1;
         main_nxt.rresp = RESP_OKAY;
         case (raddr)
            REG_CTRL: main_nxt.rdata = {{(32 - CTRL_W){1'b0}}, main_r.ctrl};
            REG_TXBYTE: main_nxt.rdata = {24'h000000, main_r.hold_byte};
            REG_STATUS: main_nxt.rdata = {28'h0000000, main_r.ovf, main_r.rx_seen,
                                          main_r.sh_cnt == 4'h0, !main_r.hold_full};
            REG_RXL: main_nxt.rdata = main_r.rx.left;
            REG_RXR: main_nxt.rdata = main_r.rx.right;
            default: begin
               main_nxt.rdata = 32'h00000000;
               main_nxt.rresp = RESP_DECERR;
            end
         endcase
      end

      // ----------------------------------------------------------------
      // I2S master timebase
      // ----------------------------------------------------------------
      // 48 kHz frame rate
      msum = {1'b0, main_r.macc} + {1'b0, slot32 ? BCLK_STEP32 : BCLK_STEP16};
      nidx = main_r.midx == last ? 6'd0 : main_r.midx + 6'd1;
      // with delay_std set, strobe leads data by one bit
      wsidx = (main_r.ctrl.delay_std && nidx == last) ? 6'd0 :
              (main_r.ctrl.delay_std ? nidx + 6'd1 : nidx);
      if (!master_on) begin
         main_nxt.macc = 16'h0000;
         main_nxt.mbclk = 1'b0;
         main_nxt.midx = last;
         main_nxt.mws = !left_lvl;
         main_nxt.mdout = 1'b0;
      end else begin
         main_nxt.macc = msum[15:0];
         if (msum[16] && !main_r.mbclk) begin
            main_nxt.mbclk = 1'b1;
            main_nxt.rise_d[0] = 1'b1;
         end else if (msum[16]) begin
            main_nxt.mbclk = 1'b0;
            main_nxt.midx = nidx;
            main_nxt.mws = wsidx < slot ? left_lvl : !left_lvl;
            if (nidx == 6'd0) begin
               main_nxt.mtx = apu_tx.left;
               main_nxt.txr = apu_tx.right;
               main_nxt.mdout = apu_tx.left[31];
               main_nxt.tx_ready = 1'b1;
            end else if (nidx == slot) begin
               main_nxt.mtx = main_r.txr;
               main_nxt.mdout = main_r.txr[31];
            end else begin
               main_nxt.mtx = {main_r.mtx[30:0], 1'b0};
               main_nxt.mdout = main_r.mtx[30];
            end
         end
      end

      rxw = {main_r.mrx[30:0], main_r.din_s2};
      if (main_r.ctrl.mode == SAP_SYNC && main_r.rise_d[1]) begin
         main_nxt.mrx = rxw;
         if (main_r.midx == slot - 6'd1) begin
            main_nxt.left_tmp = sap_align(rxw, slot32);
         end else if (main_r.midx == last) begin
            main_nxt.rx.left = main_r.left_tmp;
            main_nxt.rx.right = sap_align(rxw, slot32);
            main_nxt.rx_valid = 1'b1;
            main_nxt.rx_seen = 1'b1;
         end
      end

      if ((main_r.ctrl.mode == SAP_ASYNC_IN || main_r.ctrl.mode == SAP_ASYNC_IO) &&
          main_r.tog_s2 != main_r.tog_s3) begin
         main_nxt.rx = link_r.hold;
         main_nxt.rx_valid = 1'b1;
         main_nxt.rx_seen = 1'b1;
      end

      main_nxt.play_valid = usb_play_valid;
      if (usb_play_valid) begin
         main_nxt.play = sap_play_unpack(usb_play_word, main_r.ctrl.play_fmt);
      end
      main_nxt.rec_valid = apu_rec_valid;
      if (apu_rec_valid) begin
         main_nxt.rec_word = sap_rec_pack(apu_rec, main_r.ctrl.rec_fmt);
      end

      if (!nrst) begin
         main_nxt = '0;
         main_nxt.ctrl = CTRL_RST;
         main_nxt.midx = 6'd63;
         main_nxt.mws = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      main_r <= main_nxt;
   end

   // ----------------------------------------------------------------
   // Link clock domain: I2S slave input
   // ----------------------------------------------------------------
   // source drives data, strobe and clock
   always_comb begin
      logic edge_seen;
      logic [31:0] word;
      logic [5:0] wcnt;
      logic [31:0] aligned;
      link_nxt = link_r;
      link_nxt.rst_s1 = nrst;
      link_nxt.rst_s2 = link_r.rst_s1;
      link_nxt.cfg_s1 = {main_r.ctrl.delay_std, main_r.ctrl.ws_left_high,
                         main_r.ctrl.slot32_a};
      link_nxt.cfg_s2 = link_r.cfg_s1;
      edge_seen = word_strobe_in != link_r.ws_prev;
      // delayed framing keeps one more bit
      word = link_r.cfg_s2[2] ? {link_r.sr[30:0], serial_audio_data_in} : link_r.sr;
      wcnt = link_r.cfg_s2[2] && link_r.cnt != 6'd32 ? link_r.cnt + 6'd1 : link_r.cnt;
      aligned = word << (6'd32 - wcnt);
      aligned = link_r.cfg_s2[0] ? aligned : {aligned[31:16], 16'h0000};
      link_nxt.ws_prev = word_strobe_in;
      if (!link_r.rst_s2) begin
         link_nxt.ws_prev = 1'b0;
         link_nxt.sr = 32'h00000000;
         link_nxt.cnt = 6'd0;
         link_nxt.left = 32'h00000000;
         link_nxt.hold = '0;
         link_nxt.tog = 1'b0;
      end else if (edge_seen) begin
         if (link_r.ws_prev == link_r.cfg_s2[1]) begin
            link_nxt.left = aligned;
         end else begin
            link_nxt.hold = '{left: link_r.left, right: aligned};
            link_nxt.tog = !link_r.tog;
         end
         link_nxt.sr = link_r.cfg_s2[2] ? 32'h00000000 : {31'h0, serial_audio_data_in};
         link_nxt.cnt = link_r.cfg_s2[2] ? 6'd0 : 6'd1;
      end else begin
         // slot length from the bit count
         link_nxt.sr = {link_r.sr[30:0], serial_audio_data_in};
         link_nxt.cnt = link_r.cnt == 6'd32 ? 6'd32 : link_r.cnt + 6'd1;
      end
   end

   always_ff @(posedge bit_clock_in) begin
      link_r <= link_nxt;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign axi_rsp.awready = !main_r.aw_have && !main_r.bvalid;
   assign axi_rsp.wready = !main_r.w_have && !main_r.bvalid;
   assign axi_rsp.bvalid = main_r.bvalid;
   assign axi_rsp.bresp = main_r.bresp;
   assign axi_rsp.arready = !main_r.rvalid;
   assign axi_rsp.rvalid = main_r.rvalid;
   assign axi_rsp.rdata = main_r.rdata;
   assign axi_rsp.rresp = main_r.rresp;
   assign apu_play = main_r.play;
   assign apu_play_valid = main_r.play_valid;
   assign usb_rec_word = main_r.rec_word;
   assign usb_rec_valid = main_r.rec_valid;
   assign apu_tx_ready = main_r.tx_ready;
   assign apu_rx = main_r.rx;
   assign apu_rx_valid = main_r.rx_valid;
   assign mclk_sel = main_r.ctrl.mclk_sel;
   assign uc_load_req = main_r.ctrl.burst_en && !main_r.ctrl.direct && !main_r.hold_full;
   assign bit_clock_out = main_r.mbclk;
   assign bit_clock_oe = main_r.ctrl.mode == SAP_SYNC;
   assign word_strobe_out = main_r.mws;
   assign word_strobe_oe = main_r.ctrl.mode == SAP_SYNC;
   assign serial_audio_data_out = main_r.ctrl.mode == SAP_SYNC && main_r.mdout;

   // The direct path is combinational so the pin stays in phase with the USB bits.
   always_comb begin
      burst_word_strobe_out = 1'b0;
      if (main_r.ctrl.burst_en && main_r.ctrl.direct) begin
         burst_data_pin = usb_stream_valid && usb_stream_ep == main_r.ctrl.ep &&
                          usb_stream_bit;
         burst_clock_pin = usb_stream_valid && usb_stream_ep == main_r.ctrl.ep &&
                           usb_stream_clk;
      end else if (main_r.ctrl.burst_en) begin
         burst_data_pin = main_r.sh_cnt != 4'h0 && main_r.sh_byte[7];
         burst_clock_pin = main_r.sclk;
      end else if (main_r.ctrl.mode == SAP_ASYNC_IO) begin
         burst_data_pin = main_r.mdout;
         burst_clock_pin = main_r.mbclk;
         burst_word_strobe_out = main_r.mws;
      end else begin
         burst_data_pin = 1'b0;
         burst_clock_pin = 1'b0;
      end
   end

endmodule

// >>> rtl/sap_pkg.sv
// Constants, types and register map shared by the serial audio port logic.
//
// Contract
// - Play 16m/16s/24s; record 8m/16m/16s.
// - Burst output runs beside normal playback.
// - Burst pins use burst I2S, not continuous.
// - Burst output excludes async-in-with-output mode.
// - Direct mode passes endpoint bits unretimed.
// - Controller bytes shift out on burst data.
// - Shift clock 6 MHz to 750 kHz.
// - Two ports, each 16 or 32 bit slots.
// - Master clock select 18.432/24.576/36.864 MHz.
// - Delay bit picks standard or delayed framing.
// - Word strobe polarity is programmable.
// - Sync mode: master, fixed 48 kHz.
// - Async input: slave, 6.4 to 48 kHz.
// - Async-io: burst pins give master output.
package sap_pkg;

   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned SAMPLE_HZ = 48_000;
   localparam int unsigned SHIFT_MAX_HZ = 6_000_000;
   localparam int unsigned SHIFT_MIN_HZ = 750_000;
   localparam int unsigned ACC_W = 16;
   localparam logic [15:0] BCLK_STEP32 =
      16'((64'(2 * SAMPLE_HZ) * 64'd64 * 64'd65536) / 64'(CLK_HZ));
   localparam logic [15:0] BCLK_STEP16 =
      16'((64'(2 * SAMPLE_HZ) * 64'd32 * 64'd65536) / 64'(CLK_HZ));
   localparam logic [15:0] SHIFT_STEP_MAX =
      16'((64'(2 * SHIFT_MAX_HZ) * 64'd65536) / 64'(CLK_HZ));

   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TXBYTE = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RXL = 8'h0c;
   localparam logic [7:0] REG_RXR = 8'h10;

   localparam int unsigned ST_HOLD_EMPTY = 0;
   localparam int unsigned ST_SHIFT_IDLE = 1;
   localparam int unsigned ST_RX_SEEN = 2;
   localparam int unsigned ST_OVERFLOW = 3;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   localparam logic [1:0] MCLK_18M432 = 2'b00;
   localparam logic [1:0] MCLK_24M576 = 2'b01;
   localparam logic [1:0] MCLK_36M864 = 2'b10;
   localparam logic [1:0] FMT_BAD = 2'b11;
   localparam logic [1:0] PLAY_MONO16 = 2'b00;
   localparam logic [1:0] PLAY_STEREO16 = 2'b01;
   localparam logic [1:0] PLAY_STEREO24 = 2'b10;
   localparam logic [1:0] REC_MONO8 = 2'b00;
   localparam logic [1:0] REC_MONO16 = 2'b01;
   localparam logic [1:0] REC_STEREO16 = 2'b10;

   typedef enum logic [1:0] {
      SAP_OFF = 2'b00,
      SAP_SYNC = 2'b01,
      SAP_ASYNC_IN = 2'b10,
      SAP_ASYNC_IO = 2'b11
   } sap_mode_e;

   typedef struct packed {
      logic [3:0] ep;
      logic [1:0] rec_fmt;
      logic [1:0] play_fmt;
      logic slot32_b;
      logic slot32_a;
      logic ws_left_high;
      logic delay_std;
      logic [1:0] mclk_sel;
      logic [2:0] div_sel;
      logic direct;
      logic burst_en;
      sap_mode_e mode;
   } sap_ctrl_s;

   localparam int unsigned CTRL_W = $bits(sap_ctrl_s);
   localparam sap_ctrl_s CTRL_RST = '{ep: 4'h0, rec_fmt: REC_STEREO16,
      play_fmt: PLAY_STEREO16, slot32_b: 1'b1, slot32_a: 1'b1, ws_left_high: 1'b0,
      delay_std: 1'b1, mclk_sel: MCLK_24M576, div_sel: 3'h0, direct: 1'b0,
      burst_en: 1'b0, mode: SAP_OFF};

   typedef struct packed {
      logic [31:0] left;
      logic [31:0] right;
   } sap_sample_s;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } sap_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sap_axi_rsp_s;

endpackage

// >>> tb/sap_checker.sv
// Timing assertions on the ports of the serial audio port top.
`timescale 1ns/10ps
module sap_checker (
   input wire logic clock,
   input wire logic nrst,
   input wire sap_pkg::sap_axi_req_s axi_req,
   input wire sap_pkg::sap_axi_rsp_s axi_rsp,
   input wire logic usb_play_valid,
   input wire logic apu_play_valid,
   input wire logic apu_rec_valid,
   input wire logic usb_rec_valid,
   input wire logic bit_clock_out,
   input wire logic bit_clock_oe,
   input wire logic word_strobe_oe,
   input wire logic burst_clock_pin,
   input wire logic burst_data_pin
);
   import sap_pkg::*;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);
   sequence s_wr_taken;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   // A 48 kHz frame of 64 bits gives half periods of six or seven clocks.
   sequence s_bclk_rests;
      $stable(bit_clock_out) [*5];
   endsequence
   a_wr_answer: assert property (s_wr_taken |-> ##[1:2] axi_rsp.bvalid)
      else $error("write response missing");
   a_b_release: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
      else $error("write response not released");
   a_r_release: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
      else $error("read response not released");
   a_play_follows: assert property (usb_play_valid |=> apu_play_valid)
      else $error("playback sample not passed on");
   a_rec_follows: assert property (apu_rec_valid |=> usb_rec_valid)
      else $error("record word not passed on");
   a_bclk_runs: assert property (bit_clock_oe && word_strobe_oe |-> ##[1:8] $changed(bit_clock_out))
      else $error("master bit clock stalled");
   a_burst_steady: assert property ($rose(burst_clock_pin) |-> $stable(burst_data_pin))
      else $error("burst data moved on clock rise");
   a_bclk_half: assert property (bit_clock_oe && $changed(bit_clock_out) |=> s_bclk_rests)
      else $error("master bit clock too fast");
endmodule
bind sap_top sap_checker sap_checker_i (.*);

// >>> tb/sap_partner.sv
// Behavioural I2S source framing stereo words on its own bit clock.
`timescale 1ns/10ps
module sap_partner (
   input wire logic en,
   input wire logic [31:0] left,
   input wire logic [31:0] right,
   output logic bclk,
   output logic ws,
   output logic sd
);
   logic [63:0] f;
   initial begin
      bclk = 1'b0;
      ws = 1'b0;
      sd = 1'b0;
      #3;
      forever begin
         f = {left, right};
         // Source drives all lines, moving them on the fall.
         for (int i = 0; i < 64; i++) begin
            bclk = 1'b0;
            if (en) begin
               ws = i inside {[31:62]};
               sd = f[63 - i];
            end else begin
               sd = ~sd; // The clock runs free; the idle line shows the inverse.
            end
            #7.5 bclk = 1'b1;
            #7.5;
         end
      end
   end
endmodule

// >>> tb/tb_sap_top.sv
// Self-checking bench for the serial audio port top.
`timescale 1ns/10ps
`define CHK(g, e) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      num_errors++; \
      $display("[FAIL] %0t %h %h", $time, g, e); \
   end \
end
module tb_sap_top;
   import sap_pkg::*;
   localparam int LIM = 2000;
   logic clock = 1'b0, nrst = 1'b0, usb_stream_clk = 1'b0, usb_stream_bit = 1'b0;
   logic usb_stream_valid = 1'b0, usb_play_valid = 1'b0, apu_rec_valid = 1'b0, pe = 1'b0;
   logic [3:0] usb_stream_ep = 4'h0;
   logic [47:0] usb_play_word = '0;
   sap_axi_req_s axi_req = '0;
   sap_axi_rsp_s axi_rsp;
   sap_sample_s apu_play, apu_rec = '0, apu_tx = '0, apu_rx;
   logic [31:0] usb_rec_word, pl, pr;
   logic [1:0] mclk_sel;
   logic apu_play_valid, usb_rec_valid, apu_tx_ready, apu_rx_valid, uc_load_req, v;
   logic bit_clock_in, bit_clock_out, bit_clock_oe, word_strobe_in, word_strobe_out;
   logic word_strobe_oe, serial_audio_data_in, serial_audio_data_out, burst_clock_pin;
   logic burst_data_pin, burst_word_strobe_out;
   logic [7:0] b;
   int num_errors = 0, comparisons = 0, n;
   sap_ctrl_s c;
   always #12.5 clock = ~clock;
   sap_top sap_top_i (.*);
   sap_partner sap_partner_i (.en(pe), .left(pl), .right(pr), .bclk(bit_clock_in),
      .ws(word_strobe_in), .sd(serial_audio_data_in));
   task automatic end_sim();
      if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic guard();
      if (n >= LIM) begin
         num_errors++;
         end_sim();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge clock);
      axi_req <= '{1'b1, a, 1'b1, d, 4'hf, 1'b1, 1'b0, 8'h00, 1'b0};
      for (n = 0; n < LIM && !axi_rsp.bvalid; n++) begin
         @(posedge clock);
         if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
         if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      end
      axi_req.bready <= 1'b0;
      `CHK(axi_rsp.bresp, e)
      guard();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge clock);
      axi_req <= '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
      for (n = 0; n < LIM && !axi_rsp.rvalid; n++) begin
         @(posedge clock);
         if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      end
      axi_req.rready <= 1'b0;
      `CHK({axi_rsp.rresp, axi_rsp.rdata}, {e, d})
      guard();
   endtask
   // Waits for a sampled rising edge of a port, leaving one less than the cycle count in n.
   task automatic rise(ref logic s);
      logic p;
      p = s;
      for (n = 0; n < LIM; n++) begin
         @(posedge clock);
         if (s && !p) break;
         p = s;
      end
      guard();
   endtask
   initial begin
      void'($urandom(32'h7d5d));
      c = 21'h13a80;
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      rd(REG_CTRL, 32'h00013a80, RESP_OKAY);
      rd(8'h14, 32'h0, RESP_DECERR);
      for (int i = 0; i < 3; i++) begin
         c.mclk_sel = 2'(i);
         wr(REG_CTRL, 32'(c), RESP_OKAY);
         `CHK(mclk_sel, 2'(i))
      end
      c.burst_en = 1'b1;
      c.mode = SAP_ASYNC_IO;
      wr(REG_CTRL, 32'(c), RESP_SLVERR);
      c.mode = SAP_OFF;
      c.div_sel = 3'($urandom_range(7));
      b = 8'($urandom);
      wr(REG_CTRL, 32'(c), RESP_OKAY);
      wr(REG_TXBYTE, {24'h0, b}, RESP_OKAY);
      for (int i = 7; i >= 0; i--) begin
         rise(burst_clock_pin);
         `CHK(burst_data_pin, b[i])
      end
      `CHK(uc_load_req, 1'b1)
      c.direct = 1'b1;
      c.ep = 4'($urandom);
      wr(REG_CTRL, 32'(c), RESP_OKAY);
      usb_stream_valid <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         v = 1'($urandom);
         usb_stream_ep <= c.ep ^ {3'h0, i == 7};
         usb_stream_clk <= 1'b0;
         usb_stream_bit <= v;
         repeat (4) @(posedge clock);
         usb_stream_clk <= 1'b1;
         repeat (4) @(posedge clock);
         `CHK(burst_data_pin, v && i != 7)
      end
      apu_rec <= {32'($urandom), 32'($urandom)};
      apu_rec_valid <= 1'b1;
      usb_play_word <= {16'($urandom), 32'($urandom)};
      usb_play_valid <= 1'b1;
      @(posedge clock);
      apu_rec_valid <= 1'b0;
      usb_play_valid <= 1'b0;
      @(posedge clock);
      `CHK(usb_rec_word, {apu_rec.right[31:16], apu_rec.left[31:16]})
      `CHK(apu_play, {usb_play_word[15:0], 16'h0000, usb_play_word[31:16], 16'h0000})
      c = '{ep: c.ep, mclk_sel: c.mclk_sel, mode: SAP_ASYNC_IN, default: 1'b0};
      c.slot32_a = 1'b1;
      c.delay_std = 1'b1;
      c.rec_fmt = REC_STEREO16;
      wr(REG_CTRL, 32'(c), RESP_OKAY);
      pl = $urandom;
      pr = $urandom;
      pe = 1'b1;
      rise(apu_rx_valid);
      rise(apu_rx_valid);
      `CHK(apu_rx, {pl, pr})
      pe = 1'b0;
      c.mode = SAP_SYNC;
      wr(REG_CTRL, 32'(c), RESP_OKAY);
      rise(word_strobe_out);
      rise(word_strobe_out);
      `CHK((n + 1) inside {CLK_HZ / SAMPLE_HZ, CLK_HZ / SAMPLE_HZ + 1}, 1'b1)
      `CHK(bit_clock_oe, 1'b1)
      end_sim();
   end
endmodule
